// ### verilog/drc_dram_control.v
// DRAM controller: address mux, strobes, refresh arbitration, control registers
//
// Function
// RULE1: Row then column address go out on the shared low address lines per access.
// RULE2: The board wires A16 and A7-A0, adding A17 or A18-A16 for banked sizes.
// RULE3: Refresh is CAS before RAS every 128/88/64/44/32/22/16/11 clocks by bits 2:0.
// RULE4: Bit 5 maps 80000H-BFFFFH as DRAM and turns three port pins into strobes.
// RULE5: With DRAM on, bit 4 maps C0000H-FFFFFH to the top bank, else it is ignored.
// RULE6: A separate bank register extends DRAM up to 4 MB behind a fixed window; the code drives only bank[2:0], 8 banks of 256 KB = 2 MB.
// RULE7: Refresh runs alongside any bus cycle that is not a DRAM access.
// RULE8: Refresh wins a tie with a DRAM access and the CPU waits meanwhile.
// RULE9: Refresh requested during a DRAM access starts after that access ends.
// RULE10: A DRAM access requested during refresh waits until refresh ends.
// RULE11: Each DRAM access takes three clocks regardless of wait-state setting.
// RULE12: External ready always stretches a DRAM cycle; the board drives it.
// RULE13: DMA memory-to-memory goes out as two separate ordinary accesses.
// RULE14: Bus, strobes, data and ready follow the concurrent cycle during refresh.
// RULE15: Refresh counter, strobe timing and bank register use two I/O registers.
// RULE16: A clock counter raises refresh at the chosen interval and restarts.
`timescale 1ns/1ps
`default_nettype none
`include "drc_regs.vh"
module drc_dram_control (
    input  wire        core_clk,
    input  wire        reset_n,
    input  wire        io_write,
    input  wire        io_read,
    input  wire [7:0]  io_addr,
    input  wire [7:0]  io_wdata,
    output reg  [7:0]  io_rdata,
    input  wire        mem_req,
    input  wire [19:0] mem_addr,
    output wire        cpu_wait,
    output wire        mem_done,
    input  wire        external_ready_in,
    output reg  [7:0]  dram_addr,
    output reg  [2:0]  dram_bank_addr,
    output wire        dram_region_hit,
    output reg         ras_n,
    output reg         cas_n,
    output reg         debug_upper_select_n,
    input  wire [2:0]  port_out,
    output wire        port1_bit1,
    output wire        port1_bit2,
    output wire        port1_bit3,
    output wire [7:0]  dram_config_control,
    output wire [7:0]  dram_bank_select
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ACC  = 2'h1;
    localparam ST_REF  = 2'h2;

    reg  [1:0] rst_sync;
    wire       rst_n = rst_sync[1];
    reg  [1:0] rdy_sync;
    wire       ready_s = rdy_sync[1];
    reg  [7:0] cfg;
    reg  [7:0] bank;
    reg  [1:0] state;
    reg  [1:0] phase;
    reg        ref_pending;
    reg        upper_hit;
    wire       ref_tick;
    wire       dram_on = cfg[`DRC_CFG_ENABLE_BIT];

    assign dram_config_control = cfg;
    assign dram_bank_select    = bank;

    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdy_sync <= 2'b11;
        else
            rdy_sync <= {rdy_sync[0], external_ready_in};
    end

    // RULE4: DRAM window; RULE5: upper bank only when DRAM on
    wire win_dram  = dram_on && (mem_addr[19:18] == `DRC_DRAM_BASE_HI);
    wire win_upper = dram_on && cfg[`DRC_CFG_UPPER_BIT]
                     && (mem_addr[19:18] == `DRC_UPPER_BASE_HI);
    assign dram_region_hit = win_dram || win_upper;

    // RULE15: two I/O-mapped registers
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg  <= `DRC_CFG_RESET;
            bank <= `DRC_BANK_RESET;
        end
        else if (io_write)
        begin
            if (io_addr == `DRC_OFS_CONFIG)
                cfg <= io_wdata;
            else if (io_addr == `DRC_OFS_BANK_SELECT)
                bank <= io_wdata;
        end
    end

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            io_rdata <= 8'h00;
        else if (io_read && io_addr == `DRC_OFS_CONFIG)
            io_rdata <= cfg;
        else if (io_read && io_addr == `DRC_OFS_BANK_SELECT)
            io_rdata <= bank;
        else
            io_rdata <= 8'h00;
    end

    drc_refresh_timer u_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .enable   (dram_on),
        .rate     (cfg[`DRC_CFG_RATE_MSB:`DRC_CFG_RATE_LSB]),
        .tick     (ref_tick)
    );

    // Ready stretches only the last access clock
    wire acc_last = (state == ST_ACC) && (phase == `DRC_ACCESS_CLOCKS - 2'h1);
    wire ref_last = (state == ST_REF) && (phase == `DRC_REFRESH_CLOCKS - 2'h1);
    // RULE12: ready always honoured
    wire acc_end  = acc_last && ready_s;
    assign mem_done = acc_end;
    // RULE10: wait while refresh or access busy
    // RULE8: tie gives refresh, CPU waits
    assign cpu_wait = mem_req && dram_region_hit && !acc_end;

    // A tick seen in idle starts refresh at once; only a busy tick waits,
    // otherwise one tick would give two refresh cycles
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            ref_pending <= 1'b0;
        else if (ref_tick && state != ST_IDLE)
            ref_pending <= 1'b1;
        else if (state == ST_IDLE)
            ref_pending <= 1'b0;
    end

    wire ref_want = ref_tick || ref_pending;

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= ST_IDLE;
            phase     <= 2'h0;
            upper_hit <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    phase <= 2'h0;
                    // RULE8: refresh first on a tie
                    // RULE7: refresh free of other bus cycles
                    if (ref_want && dram_on)
                        state <= ST_REF;
                    // RULE13: each DMA half is an ordinary request
                    else if (mem_req && dram_region_hit)
                    begin
                        state     <= ST_ACC;
                        upper_hit <= win_upper;
                    end
                end
                ST_ACC:
                begin
                    // RULE11: three clocks, the last one held while ready_s is low
                    if (acc_end)
                        state <= ST_IDLE;
                    else if (!acc_last)
                        phase <= phase + 2'h1;
                end
                ST_REF:
                begin
                    if (ref_last)
                        state <= ST_IDLE;
                    else
                        phase <= phase + 2'h1;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // RULE9: refresh deferred by the ST_ACC hold above
    // RULE1: row on phase 0, column after
    // RULE6: bank lines from bank register, top bank forced
    // RULE14: refresh leaves bus lines to the other cycle
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dram_addr            <= 8'h00;
            dram_bank_addr       <= 3'h0;
            ras_n                <= 1'b1;
            cas_n                <= 1'b1;
            debug_upper_select_n <= 1'b1;
        end
        else
        begin
            debug_upper_select_n <= !(state == ST_ACC && upper_hit);
            if (state == ST_ACC)
            begin
                ras_n          <= 1'b0;
                cas_n          <= (phase == 2'h0);
                dram_addr      <= (phase == 2'h0) ? mem_addr[15:8] : mem_addr[7:0];
                dram_bank_addr <= upper_hit ? 3'h7 : bank[2:0];
                if (acc_end)
                begin
                    ras_n <= 1'b1;
                    cas_n <= 1'b1;
                end
            end
            // RULE3: CAS falls before RAS
            else if (state == ST_REF)
            begin
                cas_n <= ref_last;
                ras_n <= ref_last || (phase == 2'h0);
            end
            else
            begin
                ras_n <= 1'b1;
                cas_n <= 1'b1;
            end
        end
    end

    // RULE4: pins are strobes or port bits
    assign port1_bit1 = dram_on ? ras_n : port_out[0];
    assign port1_bit2 = dram_on ? cas_n : port_out[1];
    assign port1_bit3 = dram_on ? debug_upper_select_n : port_out[2];
endmodule // drc_dram_control
`default_nettype wire

// ### verilog/drc_regs.vh
// Register offsets, field positions, reset values and timing counts of the DRAM controller
`ifndef DRC_REGS_VH
`define DRC_REGS_VH
`define DRC_OFS_BANK_SELECT   8'h1B
`define DRC_OFS_CONFIG        8'h1E
`define DRC_CFG_RATE_LSB      0
`define DRC_CFG_RATE_MSB      2
`define DRC_CFG_UPPER_BIT     4
`define DRC_CFG_ENABLE_BIT    5
`define DRC_CFG_RESET         8'h00
`define DRC_BANK_RESET        8'h00
`define DRC_INT_128           8'h80
`define DRC_INT_88            8'h58
`define DRC_INT_64            8'h40
`define DRC_INT_44            8'h2C
`define DRC_INT_32            8'h20
`define DRC_INT_22            8'h16
`define DRC_INT_16            8'h10
`define DRC_INT_11            8'h0B
`define DRC_ACCESS_CLOCKS     2'h3
`define DRC_REFRESH_CLOCKS    2'h3
`define DRC_DRAM_BASE_HI      2'h2
`define DRC_UPPER_BASE_HI     2'h3
`endif

// ### verilog/drc_refresh_timer.v
// Refresh interval timer raising a one-cycle refresh request
`timescale 1ns/1ps
`default_nettype none
`include "drc_regs.vh"
module drc_refresh_timer (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       enable,
    input  wire [2:0] rate,
    output reg        tick
);
    reg  [7:0] count;

    function [7:0] drc_interval;
        input [2:0] code;
        begin
            case (code)
                3'h0: drc_interval = `DRC_INT_128;
                3'h1: drc_interval = `DRC_INT_88;
                3'h2: drc_interval = `DRC_INT_64;
                3'h3: drc_interval = `DRC_INT_44;
                3'h4: drc_interval = `DRC_INT_32;
                3'h5: drc_interval = `DRC_INT_22;
                3'h6: drc_interval = `DRC_INT_16;
                default: drc_interval = `DRC_INT_11;
            endcase
        end
    endfunction

    // RULE16: count, request, restart
    // RULE3: interval from rate code
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= 8'h00;
            tick  <= 1'b0;
        end
        else if (!enable)
        begin
            count <= 8'h00;
            tick  <= 1'b0;
        end
        else if (count >= drc_interval(rate) - 8'h01)
        begin
            count <= 8'h00;
            tick  <= 1'b1;
        end
        else
        begin
            count <= count + 8'h01;
            tick  <= 1'b0;
        end
    end
endmodule // drc_refresh_timer
`default_nettype wire

// ### test/drc_chk.sv
// Port-level assertions for the DRAM controller
`timescale 1ns/1ps
`default_nettype none
module drc_chk (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        mem_req,
    input wire logic [19:0] mem_addr,
    input wire logic        cpu_wait,
    input wire logic        mem_done,
    input wire logic        external_ready_in,
    input wire logic [7:0]  dram_addr,
    input wire logic        dram_region_hit,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        debug_upper_select_n,
    input wire logic [2:0]  port_out,
    input wire logic        port1_bit1,
    input wire logic        port1_bit3,
    input wire logic [7:0]  dram_config_control
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    pin_mux_a: assert property (
        port1_bit1 == (dram_config_control[5] ? ras_n : port_out[0]) &&
        port1_bit3 == (dram_config_control[5] ? debug_upper_select_n : port_out[2]))
        else $error("pin mux wrong");
    dram_off_a: assert property (!dram_config_control[5] |-> !dram_region_hit)
        else $error("hit while off");
    region_map_a: assert property (dram_config_control[5] |-> dram_region_hit ==
        (mem_addr[19:18] == 2'h2 || (mem_addr[19:18] == 2'h3 && dram_config_control[4])))
        else $error("region decode wrong");
    row_col_a: assert property ($fell(ras_n) && cas_n |-> dram_addr == mem_addr[15:8]
        ##1 !cas_n && dram_addr == mem_addr[7:0]) else $error("row or column wrong");
    ref_cbr_a: assert property ($fell(cas_n) && ras_n |=> !ras_n ##[1:2] ras_n && cas_n)
        else $error("refresh strobes wrong");
    wait_hold_a: assert property (!cas_n && ras_n |-> !mem_done [*3])
        else $error("access ended during refresh");
    ready_stall_a: assert property (mem_done |-> $past(external_ready_in, 2))
        else $error("done while not ready");
    done_end_a: assert property (mem_done |-> !ras_n && !cas_n ##1 ras_n && cas_n)
        else $error("access end wrong");
endmodule // drc_chk
bind drc_dram_control drc_chk i_chk (.core_clk, .reset_n, .mem_req, .mem_addr, .cpu_wait,
    .mem_done, .external_ready_in, .dram_addr, .dram_region_hit, .ras_n, .cas_n,
    .debug_upper_select_n, .port_out, .port1_bit1, .port1_bit3, .dram_config_control);
`default_nettype wire

// ### test/drc_dram_model.sv
// Behavioural DRAM on the strobes: address capture, refresh count, slow ready
`timescale 1ns/1ps
`default_nettype none
module drc_dram_model (
    input  wire logic       core_clk,
    input  wire logic       ras_n,
    input  wire logic       cas_n,
    input  wire logic [7:0] dram_addr,
    input  wire logic       slow,
    output var  logic       external_ready_in,
    output var  logic [7:0] row,
    output var  logic [7:0] col,
    output var  int         n_ref
);
    logic ras_q;
    logic cas_q;
    initial
    begin
        {ras_q, cas_q, external_ready_in} = 3'h7;
        n_ref = 0;
    end
    always @(posedge core_clk)
    begin
        ras_q <= ras_n;
        cas_q <= cas_n;
        if (!cas_n && cas_q && ras_n)
            n_ref <= n_ref + 1;
        if (!ras_n && ras_q && cas_n)
            row <= dram_addr;
        if (!cas_n && cas_q && !ras_n)
            col <= dram_addr;
    end
    always @(negedge core_clk)
        external_ready_in <= !slow || ($urandom % 3 != 0);
endmodule // drc_dram_model
`default_nettype wire

// ### test/test_dram_refresh_and_mux_control.sv
// Self-checking bench: registers, refresh gaps, pin reuse, random DRAM accesses
`timescale 1ns/1ps
`default_nettype none
module test_dram_refresh_and_mux_control;
    logic        core_clk, reset_n, io_write, io_read, mem_req, slow, cpu_wait, mem_done;
    logic        external_ready_in, dram_region_hit, ras_n, cas_n, debug_upper_select_n;
    logic        port1_bit1, port1_bit2, port1_bit3;
    logic [7:0]  io_addr, io_wdata, io_rdata, dram_addr, row, col, b, cfg, cfg_q, bank_q;
    logic [2:0]  port_out, dram_bank_addr;
    logic [19:0] mem_addr, a;
    int          mismatches, n_tests, n_ref, k;
    drc_dram_control i_dut (.core_clk, .reset_n, .io_write, .io_read, .io_addr, .io_wdata,
        .io_rdata, .mem_req, .mem_addr, .cpu_wait, .mem_done, .external_ready_in,
        .dram_addr, .dram_bank_addr, .dram_region_hit, .ras_n, .cas_n,
        .debug_upper_select_n, .port_out, .port1_bit1, .port1_bit2, .port1_bit3,
        .dram_config_control(cfg_q), .dram_bank_select(bank_q));
    drc_dram_model i_mem (.core_clk, .ras_n, .cas_n, .dram_addr, .slow,
        .external_ready_in, .row, .col, .n_ref);
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    function automatic int gap(input logic [2:0] c);
        int t[8] = '{128, 88, 64, 44, 32, 22, 16, 11};
        return t[c];
    endfunction
    task automatic check(input logic [19:0] got, input logic [19:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Extra idle edge so back-to-back writes never retoggle the strobe at once
    task automatic io_wr(input logic [7:0] ad, input logic [7:0] d);
        {io_addr, io_wdata, io_write} = {ad, d, 1'b1};
        @(negedge core_clk);
        io_write = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic io_rd(input logic [7:0] ad, input logic [7:0] e);
        {io_addr, io_read} = {ad, 1'b1};
        @(negedge core_clk);
        io_read = 1'b0;
        check(io_rdata, e, "io_rdata");
        @(negedge core_clk);
    endtask
    task automatic wait_ref();
        int n0;
        n0 = n_ref;
        for (k = 0; k < 300 && n_ref == n0; k++)
            @(negedge core_clk);
    endtask
    task automatic access(input logic [2:0] bank);
        mem_req = 1'b1;
        @(negedge core_clk);
        check(cpu_wait, 1'b1, "cpu_wait");
        for (k = 0; k < 80 && !mem_done; k++)
            @(negedge core_clk);
        check(mem_done, 1'b1, "mem_done");
        check(cpu_wait, 1'b0, "cpu_wait end");
        check(debug_upper_select_n, !a[18], "upper select");
        mem_req = 1'b0;
        check(dram_bank_addr, bank, "bank");
        // Column is latched by the memory on the edge after CAS falls, the closing edge unless ready stalls
        @(negedge core_clk);
        check(row, a[15:8], "row");
        check(col, a[7:0], "col");
    endtask
    initial
    begin
        #400000;
        mismatches++;
        print_verdict();
    end
    initial
    begin
        {io_write, io_read, mem_req, slow, reset_n} = 5'h00;
        {io_addr, io_wdata, port_out, mem_addr} = 39'h0;
        mismatches = 0;
        n_tests = 0;
        void'($urandom(32'hBA8F));
        repeat (5) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge core_clk);
        io_rd(8'h1E, 8'h00);
        io_rd(8'h1B, 8'h00);
        io_rd(8'h10, 8'h00);
        // First refresh after a rewrite may be short, so time the second gap
        for (int c = 0; c < 8; c++)
        begin
            io_wr(8'h1E, {5'h04, c[2:0]});
            wait_ref();
            wait_ref();
            check(k, gap(c[2:0]), "refresh gap");
        end
        io_wr(8'h1E, 8'h00);
        port_out = 3'($urandom);
        mem_addr = 20'h80000;
        @(negedge core_clk);
        check({port1_bit3, port1_bit2, port1_bit1}, port_out, "port pins");
        check(dram_region_hit, 1'b0, "hit off");
        for (int i = 0; i < 24; i++)
        begin
            b = 8'($urandom);
            cfg = {2'h0, 1'b1, 1'($urandom), 1'b0, 3'($urandom)};
            a = {1'b1, 19'($urandom)};
            slow = 1'($urandom);
            io_wr(8'h1B, b);
            io_wr(8'h1E, cfg);
            check(cfg_q, cfg, "config copy");
            check(bank_q, b, "bank copy");
            io_rd(8'h1B, b);
            mem_addr = a;
            @(negedge core_clk);
            check(dram_region_hit, !a[18] || cfg[4], "hit");
            if (!a[18] || cfg[4])
            begin
                access(a[18] ? 3'h7 : b[2:0]);
                a = a ^ 20'h00F0F;
                mem_addr = a;
                access(a[18] ? 3'h7 : b[2:0]);
            end
        end
        print_verdict();
    end
endmodule // test_dram_refresh_and_mux_control
`default_nettype wire
